// ==== design/channel_quality_monitor.sv ====
// Channel quality monitor: per-pair slicer error filter, error figure,
// quality index, capture and worst-case tracking.
// Assumes slicer samples arrive as one strobe per symbol for all four pairs.
`timescale 1ns/1ps

// Summary of operation
// - Three-level mode slices to -128, 0, 128 with thresholds at -64 and 64.
// - Five-level mode slices to five levels with thresholds -96, -32, 32, 96.
// - Slicer error is clipped to +/-32 five-level and +/-64 three-level.
// - With enable clear, no filtering, latching, index mapping or capture happens.
// - Each sample adds the difference of absolute error and filter into the filter.
// - Square mode squares the scaled error before filtering, else absolute value.
// - The add-back is divided by two to the power of the gain field.
// - Filter divided by two to the output shift gives error 0..511, saturating.
// - Capture bit with pair number self-clears and loads the selected result.
// - Each pair's filter value is latched every 125,000 symbols; captures read it.
// - Largest error since the last result read is kept, restarting on that read.
// - Seven thresholds map the error figure to a quality index 0..7.
// - Capture loads the index; the lowest index since last read is kept.
// - Capture also loads the selected pair's latched mean filter value.
// - Without link the captured index reads zero; the kept lowest index reaches zero at the next latch.
module channel_quality_monitor
  import quality_pkg::*;
#(
  parameter int SYMBOLS_PER_LATCH_P = quality_pkg::SYMBOLS_PER_LATCH
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [quality_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [quality_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [quality_pkg::DATA_W-1:0] reg_rdata,
  input wire logic sample_valid,
  input wire logic [quality_pkg::PAIRS-1:0][quality_pkg::SAMPLE_W-1:0] sample_value,
  input wire logic five_level,
  input wire logic link_up
);
  import quality_pkg::*;

  localparam logic [SYM_CNT_W-1:0] SYM_LAST = SYM_CNT_W'(SYMBOLS_PER_LATCH_P - 1);

  state_type s_reg;
  state_type s_next;

  // Clipped slicer error against the nearest ideal level
  function automatic logic signed [ERR_W-1:0] slicer_error(
    input logic signed [SAMPLE_W-1:0] v,
    input logic five
  );
    logic signed [SAMPLE_W-1:0] ideal;
    logic signed [SAMPLE_W-1:0] e;
    logic signed [ERR_W-1:0] lim;
    ideal = '0;
    if (five) begin
      if (v >= THR5_OUT) ideal = LVL_FULL;
      else if (v >= THR5_IN) ideal = LVL_HALF;
      else if (v > -THR5_IN) ideal = '0;
      else if (v > -THR5_OUT) ideal = -LVL_HALF;
      else ideal = -LVL_FULL;
      lim = ERR5_MAX;
    end else begin
      if (v >= THR3_MID) ideal = LVL_FULL;
      else if (v > -THR3_MID) ideal = '0;
      else ideal = -LVL_FULL;
      lim = ERR3_MAX;
    end
    e = v - ideal;
    if (e > SAMPLE_W'(lim)) e = SAMPLE_W'(lim);
    if (e < -SAMPLE_W'(lim)) e = -SAMPLE_W'(lim);
    return ERR_W'(e);
  endfunction : slicer_error

  // Scaled error fed into the filter
  function automatic logic [SQ_W-1:0] filter_input(
    input logic signed [ERR_W-1:0] e,
    input logic five,
    input logic square
  );
    logic [6:0] mag;
    mag = e[ERR_W-1] ? 7'(-e) : 7'(e);
    if (five) mag = 7'({mag[5:0], 1'b0});
    return square ? SQ_W'(mag * mag) : SQ_W'(mag);
  endfunction : filter_input

  // Integer filter value scaled to the error figure
  function automatic logic [MSE_W-1:0] error_figure(
    input logic [SQ_W-1:0] v,
    input logic [3:0] shift
  );
    logic [SQ_W-1:0] q;
    q = v >> shift;
    return (q > SQ_W'(MSE_MAX)) ? MSE_MAX : q[MSE_W-1:0];
  endfunction : error_figure

  function automatic logic [IDX_W-1:0] map_index(
    input logic [MSE_W-1:0] m,
    input logic [THR_N-1:0][MSE_W-1:0] thr
  );
    logic [IDX_W-1:0] idx;
    idx = IDX_WORST;
    for (int n = 0; n < THR_N; n++) begin
      if (m <= thr[n]) idx = IDX_W'(n + 1);
    end
    return idx;
  endfunction : map_index

  logic [PAIRS-1:0][SQ_W-1:0] target;
  logic [PAIRS-1:0][FILT_W-1:0] filt_step;
  logic [PAIRS-1:0][MSE_W-1:0] live_mse;
  logic [PAIRS-1:0][IDX_W-1:0] live_idx;

  genvar g;
  generate
    for (g = 0; g < PAIRS; g++) begin : g_pair
      logic signed [FILT_W+1:0] diff;
      logic signed [FILT_W+1:0] sum;
      assign target[g] = filter_input(slicer_error(sample_value[g], five_level),
                                      five_level, s_reg.square);
      assign diff = $signed({2'b00, target[g], {FRAC_W{1'b0}}})
                    - $signed({2'b00, s_reg.filt[g]});
      assign sum = $signed({2'b00, s_reg.filt[g]}) + (diff >>> s_reg.gain);
      assign filt_step[g] = sum[FILT_W-1:0];
      assign live_mse[g] = error_figure(s_reg.filt[g][FILT_W-1:FRAC_W], s_reg.oshift);
      assign live_idx[g] = link_up ? map_index(live_mse[g], s_reg.thr) : IDX_WORST;
    end
  endgenerate

  logic latch_now;
  logic capture_req;
  logic [1:0] cap_pair;
  logic [MSE_W-1:0] sel_mse;

  assign latch_now = s_reg.en && sample_valid && (s_reg.sym_cnt == SYM_LAST);
  assign capture_req = reg_write && (reg_addr == CFG_REG) && reg_wdata[CFG_CAPTURE]
                       && reg_wdata[CFG_EN];
  assign cap_pair = reg_wdata[CFG_PAIR_LSB +: 2];
  assign sel_mse = error_figure(s_reg.held[cap_pair], s_reg.oshift);

  always_comb begin
    s_next = s_reg;
    if (reg_write) begin
      if (reg_addr == CFG_REG) begin
        s_next.en = reg_wdata[CFG_EN];
        s_next.square = reg_wdata[CFG_SQUARE];
        s_next.gain = reg_wdata[CFG_GAIN_LSB +: 4];
        s_next.oshift = reg_wdata[CFG_SHIFT_LSB +: 4];
        s_next.pair = cap_pair;
      end
      for (int n = 0; n < THR_N; n++) begin
        if (reg_addr == ADDR_W'(THR1_REG + n)) s_next.thr[n] = reg_wdata[MSE_W-1:0];
      end
    end
    if (reg_read) begin
      if (reg_addr == MSE_REG) s_next.wmse = '0;
      if (reg_addr == IDX_REG) s_next.widx = {PAIRS{IDX_BEST}};
    end
    if (s_reg.en && sample_valid) begin
      s_next.filt = filt_step;
      s_next.sym_cnt = latch_now ? '0 : s_reg.sym_cnt + 1'b1;
    end
    if (latch_now) begin
      for (int p = 0; p < PAIRS; p++) begin
        s_next.held[p] = s_reg.filt[p][FILT_W-1:FRAC_W];
        // A new result wins over a clearing read in the same cycle
        if (live_mse[p] > s_next.wmse[p]) s_next.wmse[p] = live_mse[p];
        if (live_idx[p] < s_next.widx[p]) s_next.widx[p] = live_idx[p];
      end
    end
    if (capture_req) begin
      s_next.cap_mse = sel_mse;
      s_next.cap_wmse = s_reg.wmse[cap_pair];
      s_next.cap_idx = link_up ? map_index(sel_mse, s_reg.thr) : IDX_WORST;
      s_next.cap_widx = s_reg.widx[cap_pair];
      s_next.cap_mean = s_reg.held[cap_pair];
    end
    s_next.rdata = '0;
    if (reg_read) begin
      case (reg_addr)
        CFG_REG: s_next.rdata = {1'b0, s_reg.pair, 1'b0, s_reg.oshift, s_reg.gain,
                                 2'b00, s_reg.square, s_reg.en};
        MSE_REG: s_next.rdata = DATA_W'(s_reg.cap_mse);
        MSE_WORST_REG: s_next.rdata = DATA_W'(s_reg.cap_wmse);
        IDX_REG: s_next.rdata = DATA_W'({s_reg.cap_widx, 1'b0, s_reg.cap_idx});
        MEAN_REG: s_next.rdata = DATA_W'(s_reg.cap_mean);
        default: begin
          for (int n = 0; n < THR_N; n++) begin
            if (reg_addr == ADDR_W'(THR1_REG + n)) s_next.rdata = DATA_W'(s_reg.thr[n]);
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_reg <= '0;
      s_reg.thr <= THR_RESET;
      s_reg.widx <= {PAIRS{IDX_BEST}};
      s_reg.cap_idx <= IDX_WORST;
      s_reg.cap_widx <= IDX_BEST;
    end else begin
      s_reg <= s_next;
    end
  end

  assign reg_rdata = s_reg.rdata;

  // Checks
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  sequence seq_cap_write;
    capture_req;
  endsequence

  sequence seq_cfg_read;
    reg_read && !reg_write && (reg_addr == CFG_REG);
  endsequence

  logic signed [ERR_W-1:0] err0;
  assign err0 = slicer_error(sample_value[0], five_level);

  a_disabled_filter_hold: assert property (!s_reg.en |=> $stable(s_reg.filt))
    else $error("filter moved while disabled");
  a_error_bound_clip: assert property (
    (five_level -> (err0 <= ERR5_MAX && err0 >= -ERR5_MAX)) &&
    (!five_level -> (err0 <= ERR3_MAX && err0 >= -ERR3_MAX)))
    else $error("slicer error out of bound");
  a_ideal_three_level: assert property (
    (!five_level && sample_value[0] == LVL_FULL) |-> err0 == '0)
    else $error("three-level ideal not zero error");
  a_ideal_five_level: assert property (
    (five_level && sample_value[0] == LVL_HALF) |-> err0 == '0)
    else $error("five-level ideal not zero error");
  a_filter_unit_step: assert property (
    (s_reg.en && sample_valid && s_reg.gain == 4'h0 && !(reg_write && reg_addr == CFG_REG))
    |=> s_reg.filt[0][FILT_W-1:FRAC_W] == $past(target[0]))
    else $error("unit gain filter did not track input");
  a_capture_self_clear: assert property (seq_cap_write ##[1:2] seq_cfg_read
    |=> !reg_rdata[CFG_CAPTURE] && reg_rdata[CFG_PAIR_LSB +: 2] == $past(s_reg.pair))
    else $error("capture bit did not self-clear");
  a_capture_loads_mse: assert property (capture_req
    |=> s_reg.cap_mse == $past(sel_mse) && s_reg.cap_mean == $past(s_reg.held[cap_pair]))
    else $error("capture did not load selected pair");
  a_mse_saturates: assert property (capture_req && (s_reg.held[cap_pair] >> s_reg.oshift)
    > SQ_W'(MSE_MAX) |=> s_reg.cap_mse == MSE_MAX)
    else $error("error figure did not saturate");
  a_latch_on_period: assert property (latch_now
    |=> s_reg.held[1] == $past(s_reg.filt[1][FILT_W-1:FRAC_W]) && s_reg.sym_cnt == '0)
    else $error("latch missed period end");
  a_worst_mse_max: assert property (latch_now |=> s_reg.wmse[2] >= $past(live_mse[2]))
    else $error("worst error lost a result");
  a_worst_clear_read: assert property (reg_read && reg_addr == IDX_REG && !latch_now
    |=> s_reg.widx == {PAIRS{IDX_BEST}})
    else $error("worst index not restarted");
  a_index_best_case: assert property (capture_req && link_up && sel_mse <= s_reg.thr[6]
    |=> s_reg.cap_idx == IDX_BEST)
    else $error("index not best under lowest threshold");
  a_no_link_zero: assert property (capture_req && !link_up
    |=> s_reg.cap_idx == IDX_WORST)
    else $error("nonzero index without link");

  // Config write asking for a capture while the enable bit is clear
  sequence seq_cap_refused;
    reg_write && (reg_addr == CFG_REG) && reg_wdata[CFG_CAPTURE] && !reg_wdata[CFG_EN];
  endsequence

  // Symbol taken while the period counter is short of its end
  sequence seq_mid_period;
    s_reg.en && sample_valid && !latch_now;
  endsequence

  // Read of the error figure with no latch in the same cycle
  sequence seq_mse_read;
    reg_read && (reg_addr == MSE_REG) && !latch_now;
  endsequence

  // Write to the first threshold slot
  sequence seq_thr_write;
    reg_write && (reg_addr == THR1_REG);
  endsequence

  // Read of the latched mean error
  sequence seq_mean_read;
    reg_read && (reg_addr == MEAN_REG);
  endsequence

  a_refused_capture_hold: assert property (seq_cap_refused
    |=> $stable(s_reg.cap_mse) && $stable(s_reg.cap_idx) && $stable(s_reg.cap_mean))
    else $error("capture taken while disabled");
  a_disabled_count_hold: assert property (!s_reg.en
    |=> $stable(s_reg.sym_cnt) && $stable(s_reg.held))
    else $error("period counter moved while disabled");
  a_count_steps: assert property (seq_mid_period
    |=> s_reg.sym_cnt == $past(s_reg.sym_cnt) + 1'b1)
    else $error("period counter missed a symbol");
  a_worst_mse_restart: assert property (seq_mse_read
    |=> s_reg.wmse == '0)
    else $error("worst error not restarted");
  a_capture_worst_loads: assert property (capture_req
    |=> s_reg.cap_wmse == $past(s_reg.wmse[cap_pair]) &&
        s_reg.cap_widx == $past(s_reg.widx[cap_pair]))
    else $error("capture did not load worst values");
  a_worst_index_min: assert property (latch_now
    |=> s_reg.widx[3] <= $past(live_idx[3]))
    else $error("worst index lost a result");
  a_index_zero_above: assert property (capture_req && sel_mse > s_reg.thr[0]
    |=> s_reg.cap_idx == IDX_WORST)
    else $error("index not zero above first threshold");
  a_threshold_write: assert property (seq_thr_write
    |=> s_reg.thr[0] == $past(reg_wdata[MSE_W-1:0]))
    else $error("threshold write lost");
  a_five_level_double: assert property (five_level && !s_reg.square
    && (err0 == ERR5_MAX || err0 == -ERR5_MAX) |-> target[0] == 13'h0040)
    else $error("five-level error not doubled");
  a_five_level_square: assert property (five_level && s_reg.square
    && (err0 == ERR5_MAX || err0 == -ERR5_MAX) |-> target[0] == 13'h1000)
    else $error("five-level error not squared after doubling");
  a_live_no_link: assert property (!link_up
    |-> live_idx == {PAIRS{IDX_WORST}})
    else $error("live index nonzero without link");
  a_mean_read_path: assert property (seq_mean_read
    |=> reg_rdata == DATA_W'($past(s_reg.cap_mean)))
    else $error("mean error read wrong");
  a_read_data_idle: assert property (!reg_read
    |=> reg_rdata == '0)
    else $error("read data stood without a read");
endmodule : channel_quality_monitor

// ==== inc/quality_pkg.sv ====
// Constants and state layout shared by the channel quality monitor.
// Assumes a single 50 MHz clock and a plain strobed register port.
package quality_pkg;
  localparam int CLK_MHZ = 50;
  localparam int DATA_W = 16;
  localparam int ADDR_W = 4;
  localparam int PAIRS = 4;
  localparam int SAMPLE_W = 10;
  localparam int ERR_W = 8;
  localparam int SQ_W = 13;
  localparam int FRAC_W = 16;
  localparam int FILT_W = SQ_W + FRAC_W;
  localparam int MSE_W = 9;
  localparam int IDX_W = 3;
  localparam int THR_N = 7;
  localparam int SYM_CNT_W = 17;
  // Latch period is 1.0 ms of line time, counted in received symbols
  localparam int LATCH_PERIOD_US = 1000;
  localparam int SYMBOLS_PER_LATCH = 125000;

  localparam logic signed [SAMPLE_W-1:0] LVL_FULL = 10'sh080;
  localparam logic signed [SAMPLE_W-1:0] LVL_HALF = 10'sh040;
  localparam logic signed [SAMPLE_W-1:0] THR3_MID = 10'sh040;
  localparam logic signed [SAMPLE_W-1:0] THR5_IN = 10'sh020;
  localparam logic signed [SAMPLE_W-1:0] THR5_OUT = 10'sh060;
  localparam logic signed [ERR_W-1:0] ERR3_MAX = 8'sh40;
  localparam logic signed [ERR_W-1:0] ERR5_MAX = 8'sh20;
  localparam logic [MSE_W-1:0] MSE_MAX = 9'h1ff;
  localparam logic [IDX_W-1:0] IDX_BEST = 3'h7;
  localparam logic [IDX_W-1:0] IDX_WORST = 3'h0;

  localparam logic [ADDR_W-1:0] CFG_REG = 4'h0;
  localparam logic [ADDR_W-1:0] MSE_REG = 4'h1;
  localparam logic [ADDR_W-1:0] MSE_WORST_REG = 4'h2;
  localparam logic [ADDR_W-1:0] IDX_REG = 4'h3;
  localparam logic [ADDR_W-1:0] MEAN_REG = 4'h4;
  localparam logic [ADDR_W-1:0] THR1_REG = 4'h5;
  localparam int CFG_EN = 0;
  localparam int CFG_SQUARE = 1;
  localparam int CFG_GAIN_LSB = 4;
  localparam int CFG_SHIFT_LSB = 8;
  localparam int CFG_CAPTURE = 12;
  localparam int CFG_PAIR_LSB = 13;
  localparam int IDX_WORST_LSB = 4;
  // Thresholds 7..1, rising in value and severity toward threshold 1
  localparam logic [THR_N-1:0][MSE_W-1:0] THR_RESET =
    {9'h020, 9'h030, 9'h040, 9'h060, 9'h080, 9'h0c0, 9'h100};

  typedef struct packed {
    logic en;
    logic square;
    logic [3:0] gain;
    logic [3:0] oshift;
    logic [1:0] pair;
    logic [THR_N-1:0][MSE_W-1:0] thr;
    logic [PAIRS-1:0][FILT_W-1:0] filt;
    logic [PAIRS-1:0][SQ_W-1:0] held;
    logic [PAIRS-1:0][MSE_W-1:0] wmse;
    logic [PAIRS-1:0][IDX_W-1:0] widx;
    logic [SYM_CNT_W-1:0] sym_cnt;
    logic [MSE_W-1:0] cap_mse;
    logic [MSE_W-1:0] cap_wmse;
    logic [IDX_W-1:0] cap_idx;
    logic [IDX_W-1:0] cap_widx;
    logic [SQ_W-1:0] cap_mean;
    logic [DATA_W-1:0] rdata;
  } state_type;
endpackage : quality_pkg

// ==== verif/slicer_source.sv ====
// Slicer sample source standing in for the receive equalizer of all four pairs.
// Assumes the monitor samples on the rising edge of clk.
`timescale 1ns/1ps
module slicer_source
  import quality_pkg::*;
(
  input wire logic clk,
  output logic sample_valid,
  output logic [quality_pkg::PAIRS-1:0][quality_pkg::SAMPLE_W-1:0] sample_value
);
  initial begin
    sample_valid = 1'b0;
    sample_value = '0;
  end

  // Sends n symbols on all pairs; gap leaves an idle cycle after each one
  task automatic send(input logic [PAIRS-1:0][SAMPLE_W-1:0] v, input int n, input bit gap);
    for (int i = 0; i < n; i++) begin
      @(posedge clk);
      sample_valid <= 1'b1;
      sample_value <= v;
      if (gap) begin
        @(posedge clk);
        sample_valid <= 1'b0;
        sample_value <= ~v;
      end
    end
    @(posedge clk);
    sample_valid <= 1'b0;
    // Idle lines never repeat the last symbol
    sample_value <= ~v;
  endtask : send
endmodule : slicer_source

// ==== verif/testbench.sv ====
// Self-checking bench for the channel quality monitor.
// Assumes the slicer source model and a latch period shortened to 8 symbols.
`timescale 1ns/1ps
module testbench;
  import quality_pkg::*;
  localparam int LATCH = 8;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0;
  logic reg_write = 1'b0;
  logic reg_read = 1'b0;
  logic [DATA_W-1:0] reg_rdata;
  logic sample_valid;
  logic [PAIRS-1:0][SAMPLE_W-1:0] sample_value;
  logic five_level = 1'b0;
  logic link_up = 1'b1;
  int mismatches = 0;
  int n_compared = 0;

  always #10 clk = ~clk;

  channel_quality_monitor #(.SYMBOLS_PER_LATCH_P(LATCH)) dut (
    .clk(clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_write(reg_write),
    .reg_read(reg_read),
    .reg_rdata(reg_rdata),
    .sample_valid(sample_valid),
    .sample_value(sample_value),
    .five_level(five_level),
    .link_up(link_up)
  );

  slicer_source src (.clk(clk), .sample_valid(sample_valid), .sample_value(sample_value));

  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, mismatches);
    if (mismatches == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask : end_of_test

  task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp, input string m);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR at %0t: %s got %h expected %h", $time, m, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_write <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask : wr

  task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
    @(posedge clk);
    reg_read <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_read <= 1'b0;
    #1;
    d = reg_rdata;
  endtask : rd

  task automatic do_reset();
    rst <= 1'b1;
    repeat (16) @(posedge clk);
    rst <= 1'b0;
  endtask : do_reset

  function automatic logic [DATA_W-1:0] cfg(bit sq, int g, int sh, bit cap, int p);
    return {1'b0, 2'(p), cap, 4'(sh), 4'(g), 2'b00, sq, 1'b1};
  endfunction : cfg

  function automatic logic [PAIRS-1:0][SAMPLE_W-1:0] all4(int v);
    return {PAIRS{SAMPLE_W'(v)}};
  endfunction : all4

  // Integer part after seven updates from zero, the value latched on the eighth
  function automatic int filt(int x, int g);
    longint f = 0;
    repeat (LATCH - 1) f = f + (((longint'(x) <<< 16) - f) >>> g);
    return int'(f >>> 16);
  endfunction : filt

  task automatic capture(bit sq, int g, int sh, int p);
    wr(CFG_REG, cfg(sq, g, sh, 0, p));
    wr(CFG_REG, cfg(sq, g, sh, 1, p));
  endtask : capture

  task automatic t_reset();
    logic [DATA_W-1:0] d;
    rd(CFG_REG, d);
    chk(d, 16'h0000, "config");
    rd(MSE_WORST_REG, d);
    chk(d, 16'h0000, "worst error");
    rd(IDX_REG, d);
    chk(d, 16'h0070, "index");
    for (int n = 0; n < THR_N; n++) begin
      rd(THR1_REG + ADDR_W'(n), d);
      chk(d, DATA_W'(THR_RESET[n]), "threshold");
    end
    wr(THR1_REG, 16'hffff);
    rd(THR1_REG, d);
    chk(d, 16'h01ff, "threshold write");
    wr(THR1_REG, DATA_W'(THR_RESET[0]));
    wr(4'hc, 16'hffff);
    rd(4'hc, d);
    chk(d, 16'h0000, "unmapped");
  endtask : t_reset

  task automatic t_disabled();
    logic [DATA_W-1:0] d;
    wr(CFG_REG, 16'h1000);
    src.send(all4(138), LATCH, 1'b1);
    wr(CFG_REG, cfg(0, 0, 0, 1, 0));
    rd(CFG_REG, d);
    chk(d, cfg(0, 0, 0, 0, 0), "capture bit");
    rd(MEAN_REG, d);
    chk(d, 16'h0000, "disabled mean");
  endtask : t_disabled

  task automatic t_levels();
    int smp[12] = '{138, -70, 60, 64, 300, 69, -40, 32, 200, 138, 128, 64};
    bit lv5[12] = '{0, 0, 0, 0, 0, 1, 1, 1, 1, 0, 0, 1};
    bit sq[12] = '{0, 0, 0, 0, 0, 0, 0, 0, 1, 1, 0, 0};
    int ex[12] = '{10, 58, 60, 64, 64, 10, 48, 64, 4096, 100, 0, 0};
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 12; i++) begin
      five_level <= lv5[i];
      wr(CFG_REG, cfg(sq[i], 0, 0, 0, 0));
      src.send(all4(smp[i]), LATCH, 1'b0);
      capture(sq[i], 0, 0, i % PAIRS);
      rd(MEAN_REG, d);
      chk(d, DATA_W'(ex[i]), "mean error");
    end
    five_level <= 1'b0;
  endtask : t_levels

  task automatic t_gain();
    int gs[2] = '{1, 3};
    logic [DATA_W-1:0] d;
    for (int i = 0; i < 2; i++) begin
      do_reset();
      wr(CFG_REG, cfg(0, gs[i], 0, 0, 0));
      src.send(all4(60), LATCH - 1, 1'b1);
      capture(0, gs[i], 0, 0);
      rd(MEAN_REG, d);
      chk(d, 16'h0000, "before latch");
      src.send(all4(60), 1, 1'b0);
      capture(0, gs[i], 0, 0);
      rd(MEAN_REG, d);
      chk(d, DATA_W'(filt(60, gs[i])), "gain");
    end
  endtask : t_gain

  task automatic t_mse();
    int fig[2][4] = '{'{100, 256, 16, 511}, '{6, 16, 1, 256}};
    int idx[2][4] = '{'{3, 1, 7, 0}, '{7, 7, 7, 1}};
    logic [PAIRS-1:0][SAMPLE_W-1:0] v;
    logic [DATA_W-1:0] d;
    v = {10'sd300, 10'sd132, 10'sd144, 10'sd138};
    do_reset();
    wr(CFG_REG, cfg(1, 0, 0, 0, 0));
    src.send(v, LATCH, 1'b0);
    for (int s = 0; s < 2; s++) begin
      for (int p = 0; p < PAIRS; p++) begin
        capture(1, 0, s * 4, p);
        rd(MSE_REG, d);
        chk(d, DATA_W'(fig[s][p]), "error figure");
        rd(IDX_REG, d);
        chk(d & 16'h0007, DATA_W'(idx[s][p]), "index");
      end
    end
    link_up <= 1'b0;
    capture(1, 0, 0, 2);
    rd(IDX_REG, d);
    chk(d & 16'h0007, 16'h0000, "link lost");
    link_up <= 1'b1;
  endtask : t_mse

  task automatic t_worst();
    logic [DATA_W-1:0] d;
    do_reset();
    wr(CFG_REG, cfg(1, 0, 0, 0, 0));
    src.send(all4(144), LATCH, 1'b0);
    src.send(all4(132), LATCH, 1'b0);
    capture(1, 0, 0, 1);
    rd(MSE_WORST_REG, d);
    chk(d, 16'h0100, "worst kept");
    rd(MSE_REG, d);
    chk(d, 16'h0010, "current");
    rd(IDX_REG, d);
    chk(d, 16'h0017, "worst index kept");
    src.send(all4(132), LATCH, 1'b1);
    capture(1, 0, 0, 1);
    rd(MSE_WORST_REG, d);
    chk(d, 16'h0010, "worst restarted");
    rd(IDX_REG, d);
    chk(d, 16'h0077, "worst index restarted");
  endtask : t_worst

  initial begin
    do_reset();
    t_reset();
    t_disabled();
    t_levels();
    t_gain();
    t_mse();
    t_worst();
    end_of_test();
  end

  // Whole run needs a few hundred cycles; this allows twenty thousand
  initial begin
    #400000;
    mismatches++;
    $display("ERROR at %0t: watchdog expired", $time);
    end_of_test();
  end
endmodule : testbench
